// >>> core/mlsf_front_end.sv
// Purpose: serial front end of a multi-lane NOR flash (device side)
// Assumes: pins arrive asynchronously and are double synchronised to clk
// Notes:   command decode lives outside; bytes stream in and out here
// Summary of operation
// - accept clock idling low (mode 0) or idling high (mode 3).
// - sample input bits on rising serial clock, present output from falling edge.
// - both clock modes work in extended, two-lane and four-lane protocols.
// - drive output lanes only while chip select active; otherwise release them.
// - default protocol is extended; command byte arrives on lane zero only.
// - volatile write with bit6 low, bit7 high selects two-lane protocol at once.
// - volatile write with bit7 low selects four-lane protocol at once.
// - volatile write with bit6 and bit7 high, or rescue, returns to default protocol; power-on loads the nonvolatile bits.
// - nonvolatile dual bit active, with quad bit still one, starts two-lane protocol at next power-on.
// - nonvolatile quad bit cleared starts four-lane protocol at next power-on.
// - nonvolatile choice applies every power-on until its bit returns to one.
// - four-lane protocol moves command, address and data on four lanes.
// - during supply-powered program or erase, four-lane mode accepts one-lane traffic.
// - when programming supply falls, four-lane protocol resumes.
// - power-on loads protocol from nonvolatile bits; volatile writes override at once.
`include "mlsf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mlsf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready_reg,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready_reg;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      cnt_reg      <= '0;
      in_ready_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg      <= cnt_next;
      in_ready_reg <= (cnt_next != (AW+1)'(D));
    end
  end
endmodule

module mlsf_front_end (
  input  wire logic               clk,
  input  wire logic               arst_n,
  // serial pins
  input  wire logic               sck,
  input  wire logic               cs_n,
  input  wire logic [3:0]         lane_in,
  output var  logic [3:0]         lane_out_reg,
  output var  logic [3:0]         lane_oe_n_reg,
  input  wire logic               vpp_hi,
  // configuration
  input  wire logic               nv_dual_n,
  input  wire logic               nv_quad_n,
  input  wire logic               evcr_wr_stb,
  input  wire logic [7:0]         evcr_wr_data,
  input  wire logic               rescue_stb,
  input  wire logic               pe_busy,
  input  wire logic [3:0]         ext_lanes,
  input  wire logic               tx_en,
  // received byte stream
  output var  logic               rx_valid_reg,
  output var  logic [7:0]         rx_data_reg,
  output var  logic               rx_first_reg,
  // transmit byte stream
  input  wire logic               tx_valid,
  input  wire logic [7:0]         tx_data,
  output logic                    tx_ready,
  // status
  output var  mlsf_pkg::mlsf_proto_t proto_reg,
  output var  mlsf_pkg::mlsf_proto_t eff_proto_reg,
  output var  logic               cpol_reg
);
  import mlsf_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic       sck_s1, sck_s2, sck_d;
  logic       cs_s1, cs_s2, cs_d;
  logic       vpp_s1, vpp_s2;
  logic [3:0] lane_s1, lane_s2;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {cs_s1, cs_s2, cs_d}    <= 3'h7;
      {vpp_s1, vpp_s2}        <= 2'h0;
      lane_s1                 <= 4'h0;
      lane_s2                 <= 4'h0;
    end
    else
    begin
      sck_s1  <= sck;
      sck_s2  <= sck_s1;
      sck_d   <= sck_s2;
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      vpp_s1  <= vpp_hi;
      vpp_s2  <= vpp_s1;
      lane_s1 <= lane_in;
      lane_s2 <= lane_s1;
    end
  end

  logic cs_act, sck_rise, sck_fall;
  assign cs_act   = !cs_s2;
  assign sck_rise = cs_act && sck_s2 && !sck_d;
  assign sck_fall = cs_act && !sck_s2 && sck_d;

  // ----------------------------------------
  // protocol selection
  // ----------------------------------------
  logic        boot_done_reg;
  mlsf_proto_t nv_proto;
  mlsf_proto_t evcr_proto;
  mlsf_proto_t eff_next;

  always_comb
  begin
    nv_proto = MLSF_EXT;
    if (!nv_quad_n)
      nv_proto = MLSF_QUAD;
    else if (!nv_dual_n)
      nv_proto = MLSF_DUAL;
    evcr_proto = MLSF_EXT;
    if (!evcr_wr_data[`MLSF_EVCR_QUAD_BIT])
      evcr_proto = MLSF_QUAD;
    else if (!evcr_wr_data[`MLSF_EVCR_DUAL_BIT])
      evcr_proto = MLSF_DUAL;
    // one-lane fallback while programming on the external supply
    eff_next = proto_reg;
    if (proto_reg == MLSF_QUAD && pe_busy && vpp_s2)
      eff_next = MLSF_EXT;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_done_reg <= 1'b0;
      proto_reg     <= MLSF_EXT;
    end
    else if (!boot_done_reg)
    begin
      boot_done_reg <= 1'b1;
      proto_reg     <= nv_proto;
    end
    else if (evcr_wr_stb)
      proto_reg <= evcr_proto;
    else if (rescue_stb)
      proto_reg <= MLSF_EXT;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      eff_proto_reg <= MLSF_EXT;
    else
      eff_proto_reg <= eff_next;
  end

  // ----------------------------------------
  // lane width per bit
  // ----------------------------------------
  logic       first_byte_reg;
  logic [3:0] lw;

  always_comb
  begin
    case (eff_proto_reg)
      MLSF_QUAD: lw = 4'h4;
      MLSF_DUAL: lw = 4'h2;
      MLSF_EXT:  lw = first_byte_reg ? 4'h1 : ext_lanes;
      default:   lw = 4'h1;
    endcase
  end

  // clock polarity seen at frame start
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cpol_reg <= 1'b0;
    else if (cs_d && !cs_s2)
      cpol_reg <= sck_s2;
  end

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_sh_next;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;

  always_comb
  begin
    case (lw)
      4'h4:    rx_sh_next = {rx_sh_reg[3:0], lane_s2};
      4'h2:    rx_sh_next = {rx_sh_reg[5:0], lane_s2[1:0]};
      default: rx_sh_next = {rx_sh_reg[6:0], lane_s2[0]};
    endcase
    rx_cnt_next = rx_cnt_reg + lw;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_sh_reg      <= 8'h00;
      rx_cnt_reg     <= 4'h0;
      first_byte_reg <= 1'b1;
      rx_valid_reg   <= 1'b0;
      rx_data_reg    <= 8'h00;
      rx_first_reg   <= 1'b0;
    end
    else
    begin
      rx_valid_reg <= 1'b0;
      if (!cs_act)
      begin
        rx_cnt_reg     <= 4'h0;
        first_byte_reg <= 1'b1;
      end
      else if (sck_rise)
      begin
        rx_sh_reg <= rx_sh_next;
        if (rx_cnt_next >= `MLSF_BYTE_BITS)
        begin
          rx_cnt_reg     <= 4'h0;
          rx_valid_reg   <= 1'b1;
          rx_data_reg    <= rx_sh_next;
          rx_first_reg   <= first_byte_reg;
          first_byte_reg <= 1'b0;
        end
        else
          rx_cnt_reg <= rx_cnt_next;
      end
    end
  end

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;
  logic [7:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [7:0] tx_byte;
  logic       tx_have;
  logic       tx_slot;
  logic [3:0] lane_mask;
  logic [3:0] lane_bits;

  mlsf_fifo #(
    .W (`MLSF_FIFO_WIDTH),
    .D (`MLSF_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk          (clk),
    .arst_n       (arst_n),
    .in_valid     (tx_valid),
    .in_data      (tx_data),
    .in_ready_reg (tx_ready),
    .out_valid    (fifo_valid),
    .out_data     (fifo_data),
    .out_ready    (fifo_pop)
  );

  assign tx_slot  = sck_fall && tx_en && !first_byte_reg;
  assign fifo_pop = tx_slot && (tx_left_reg == 4'h0);
  assign tx_byte  = (tx_left_reg == 4'h0) ? fifo_data : tx_sh_reg;
  assign tx_have  = (tx_left_reg != 4'h0) || fifo_valid;

  always_comb
  begin
    case (lw)
      4'h4:
      begin
        lane_bits = tx_byte[7:4];
        lane_mask = `MLSF_OE_QUAD;
      end
      4'h2:
      begin
        lane_bits = {2'h0, tx_byte[7:6]};
        lane_mask = `MLSF_OE_DUAL;
      end
      default:
      begin
        lane_bits = {2'h0, tx_byte[7], 1'b0};
        lane_mask = `MLSF_OE_SINGLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sh_reg     <= 8'h00;
      tx_left_reg   <= 4'h0;
      lane_out_reg  <= 4'h0;
      lane_oe_n_reg <= `MLSF_OE_OFF;
    end
    else if (!cs_act)
    begin
      tx_left_reg   <= 4'h0;
      lane_oe_n_reg <= `MLSF_OE_OFF;
    end
    else if (tx_slot)
    begin
      if (tx_have)
      begin
        lane_out_reg  <= lane_bits;
        lane_oe_n_reg <= lane_mask;
        tx_sh_reg     <= tx_byte << lw;
        tx_left_reg   <= ((tx_left_reg == 4'h0) ? `MLSF_BYTE_BITS : tx_left_reg) - lw;
      end
      else
        lane_oe_n_reg <= `MLSF_OE_OFF;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_boot_load:
    assert property ($rose(boot_done_reg) |-> proto_reg == nv_proto)
    else $error("protocol not loaded from nonvolatile bits");
  chk_boot_quad_prio:
    assert property ($rose(boot_done_reg) && !$past(nv_quad_n) |-> proto_reg == MLSF_QUAD)
    else $error("quad boot selection lost");
  chk_evcr_quad:
    assert property (boot_done_reg && evcr_wr_stb && !evcr_wr_data[7] |=> proto_reg == MLSF_QUAD)
    else $error("volatile quad write ignored");
  chk_evcr_dual:
    assert property (boot_done_reg && evcr_wr_stb && evcr_wr_data[7:6] == 2'h2
                     |=> proto_reg == MLSF_DUAL)
    else $error("volatile dual write ignored");
  chk_evcr_revert:
    assert property (boot_done_reg && (rescue_stb && !evcr_wr_stb
                     || evcr_wr_stb && evcr_wr_data[7:6] == 2'h3) |=> proto_reg == MLSF_EXT)
    else $error("protocol did not return to extended");
  chk_fallback_ext:
    assert property (proto_reg == MLSF_QUAD && pe_busy && vpp_s2 |=> eff_proto_reg == MLSF_EXT)
    else $error("no one-lane fallback during supply program");
  chk_quad_resume:
    assert property (proto_reg == MLSF_QUAD && !vpp_s2 |=> eff_proto_reg == MLSF_QUAD)
    else $error("quad protocol not resumed");
  chk_release_idle:
    assert property (!cs_act |=> lane_oe_n_reg == `MLSF_OE_OFF)
    else $error("lanes driven while deselected");
  chk_rx_on_rise:
    assert property (rx_valid_reg |-> $past(sck_rise))
    else $error("byte completed without rising edge");
  chk_tx_on_fall:
    assert property ($changed(lane_out_reg) |-> $past(sck_fall))
    else $error("output changed away from falling edge");
  chk_cmd_lane_zero:
    assert property (eff_proto_reg == MLSF_EXT && first_byte_reg |-> lw == 4'h1)
    else $error("command byte not on single lane");

  cov_quad_boot: cover property ($rose(boot_done_reg) && proto_reg == MLSF_QUAD);
  cov_fallback:  cover property (proto_reg == MLSF_QUAD && eff_proto_reg == MLSF_EXT);
  cov_quad_byte: cover property (rx_valid_reg && eff_proto_reg == MLSF_QUAD);
  cov_tx_pop:    cover property (fifo_pop && fifo_valid);
  cov_fifo_full: cover property (!tx_ready && boot_done_reg);
endmodule

`default_nettype wire

// >>> shared/mlsf_defs.svh
// Purpose: constants for the multi-lane serial flash front end
// Assumes: included by its bare name
// Notes:   bit positions inside the configuration bytes
`ifndef MLSF_DEFS_SVH
`define MLSF_DEFS_SVH
// ----------------------------------------
// configuration bit positions
// ----------------------------------------
`define MLSF_EVCR_DUAL_BIT 6
`define MLSF_EVCR_QUAD_BIT 7
// ----------------------------------------
// serial framing
// ----------------------------------------
`define MLSF_BYTE_BITS     4'h8
`define MLSF_FIFO_WIDTH    8
`define MLSF_FIFO_DEPTH    16
`define MLSF_OE_QUAD       4'h0
`define MLSF_OE_DUAL       4'hc
`define MLSF_OE_SINGLE     4'hd
`define MLSF_OE_OFF        4'hf
`endif

// >>> shared/mlsf_pkg.sv
// Purpose: types for the multi-lane serial flash front end
// Assumes: nothing
// Notes:   protocol enumeration shared by design and bench
package mlsf_pkg;
  typedef enum logic [1:0] {MLSF_EXT, MLSF_DUAL, MLSF_QUAD} mlsf_proto_t;
endpackage

// >>> verification/mlsf_master.sv
// Purpose: bus master model driving the serial pins of the front end
// Assumes: clk is the bench clock; H clk cycles make one serial half period
// Notes:   a released lane shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module mlsf_master (
  // bench clock
  input  wire logic       clk,
  // serial pins
  output var  logic       sck,
  output var  logic       cs_n,
  output var  logic [3:0] lane_in,
  input  wire logic [3:0] lane_bus
);
  localparam int H = 8;
  logic pol = 1'h0;
  initial
  begin
    sck = 1'h0;
    cs_n = 1'h1;
    // lanes two and three double as write-protect and hold: never left floating
    lane_in = 4'h0;
  end
  task automatic hw();
    repeat (H) @(negedge clk);
  endtask
  // clock rests at its idle level outside frames
  task automatic open_f(input logic m);
    pol = m;
    sck = m;
    hw();
    cs_n = 1'h0;
    hw();
  endtask
  task automatic close_f();
    sck = pol;
    hw();
    cs_n = 1'h1;
    lane_in = ~lane_in;
    hw();
  endtask
  task automatic xfer(input int w, input logic drv, input logic [7:0] dout,
                      output logic [7:0] din);
    logic [7:0] sh;
    logic [3:0] m;
    sh = dout;
    din = 8'h00;
    m = 4'((5'h1 << w) - 5'h1);
    for (int e = 0; e < 8 / w; e++)
    begin
      sck = 1'h0;
      lane_in = drv ? 4'(sh[7:4] >> (4 - w)) : ~lane_in;
      sh = 8'(sh << w);
      hw();
      sck = 1'h1;
      din = 8'((din << w) | ((w == 1) ? 8'(lane_bus[1]) : 8'(lane_bus & m)));
      hw();
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/multi_lane_serial_flash_front_end_tb_top.sv
// Purpose: self-checking bench for the serial flash front end
// Assumes: master model drives sck, cs_n and the lanes
// Notes:   lane wires resolve the device enables against the master
`include "mlsf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module multi_lane_serial_flash_front_end_tb_top;
  import mlsf_pkg::*;
  logic clk = 1'h0, arst_n = 1'h0, vpp_hi = 1'h0, pe_busy = 1'h0, tx_en = 1'h0;
  logic nv_dual_n = 1'h1, nv_quad_n = 1'h1, evcr_wr_stb = 1'h0, rescue_stb = 1'h0;
  logic tx_valid = 1'h0;
  logic [7:0] evcr_wr_data = 8'h00, tx_data = 8'h00;
  logic [3:0] ext_lanes = 4'h1;
  logic sck, cs_n, rx_valid_reg, rx_first_reg, tx_ready, cpol_reg;
  logic [3:0] m_lane, lane_out_reg, lane_oe_n_reg;
  logic [7:0] rx_data_reg;
  logic [8:0] rx_q[$];
  mlsf_proto_t proto_reg, eff_proto_reg;
  int fail_count = 0, tests_run = 0;
  wire logic [3:0] lane_w = (lane_oe_n_reg & m_lane) | (~lane_oe_n_reg & lane_out_reg);
  always #2.5 clk = ~clk;
  mlsf_front_end uut (
    .clk, .arst_n, .sck, .cs_n, .lane_in(lane_w), .lane_out_reg, .lane_oe_n_reg,
    .vpp_hi, .nv_dual_n, .nv_quad_n, .evcr_wr_stb, .evcr_wr_data, .rescue_stb,
    .pe_busy, .ext_lanes, .tx_en, .rx_valid_reg, .rx_data_reg, .rx_first_reg,
    .tx_valid, .tx_data, .tx_ready, .proto_reg, .eff_proto_reg, .cpol_reg
  );
  mlsf_master mm (.clk, .sck, .cs_n, .lane_in(m_lane), .lane_bus(lane_w));
  always @(negedge clk)
  begin
    if (rx_valid_reg === 1'h1)
      rx_q.push_back({rx_first_reg, rx_data_reg});
  end
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic tmo();
    $display("unexpected wait: bound used up");
    fail_count++;
    final_report();
  endtask
  task automatic exp_rx(input logic [8:0] e);
    int n = 0;
    while (rx_q.size() == 0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (rx_q.size() == 0)
      tmo();
    else
      chk("rx byte", e, rx_q.pop_front());
  endtask
  task automatic boot(input logic dn, input logic qn);
    arst_n = 1'h0;
    nv_dual_n = dn;
    nv_quad_n = qn;
    repeat (5) @(negedge clk);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask
  task automatic cfg(input logic [7:0] d, input logic r);
    @(negedge clk);
    evcr_wr_stb = ~r;
    rescue_stb = r;
    evcr_wr_data = d;
    @(negedge clk);
    evcr_wr_stb = 1'h0;
    rescue_stb = 1'h0;
    @(negedge clk);
  endtask
  task automatic push(input logic [7:0] d);
    int n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tx_ready !== 1'h1 && n < 20);
    if (tx_ready !== 1'h1)
      tmo();
    tx_valid = 1'h1;
    tx_data = d;
    @(negedge clk);
    tx_valid = 1'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot();
    logic [4:0] dn = 5'h15;
    logic [4:0] qn = 5'h13;
    mlsf_proto_t ex[5] = '{MLSF_EXT, MLSF_DUAL, MLSF_QUAD, MLSF_QUAD, MLSF_EXT};
    mlsf_proto_t prev = MLSF_EXT;
    for (int i = 0; i < 5; i++)
    begin
      nv_dual_n = dn[i];
      nv_quad_n = qn[i];
      repeat (3) @(negedge clk);
      chk("proto held", 9'(prev), 9'(proto_reg));
      boot(dn[i], qn[i]);
      chk("proto boot", 9'(ex[i]), 9'(proto_reg));
      chk("eff boot", 9'(ex[i]), 9'(eff_proto_reg));
      chk("oe idle", 9'hf, 9'(lane_oe_n_reg));
      prev = ex[i];
    end
  endtask
  task automatic t_vol();
    logic [7:0] d[6] = '{8'h80, 8'h40, 8'h00, 8'hc0, 8'h7f, 8'h00};
    mlsf_proto_t ex[6] = '{MLSF_DUAL, MLSF_QUAD, MLSF_QUAD, MLSF_EXT, MLSF_QUAD, MLSF_EXT};
    for (int i = 0; i < 6; i++)
    begin
      cfg(d[i], i == 5);
      chk("proto write", 9'(ex[i]), 9'(proto_reg));
      chk("eff write", 9'(ex[i]), 9'(eff_proto_reg));
    end
  endtask
  task automatic t_frame(input logic m, input int w);
    logic [7:0] dt = 8'h96 ^ 8'(w);
    logic [7:0] d;
    cfg(w == 4 ? 8'h40 : (w == 2 ? 8'h80 : 8'hc0), 1'h0);
    push(dt);
    tx_en = 1'h1;
    rx_q.delete();
    mm.open_f(m);
    mm.xfer(w, 1'h1, 8'hb3, d);
    exp_rx(9'h1b3);
    mm.xfer(w, 1'h0, 8'h00, d);
    chk("lanes out", 9'(dt), 9'(d));
    chk("oe drive", 9'(w == 4 ? `MLSF_OE_QUAD : (w == 2 ? `MLSF_OE_DUAL : `MLSF_OE_SINGLE)),
        9'(lane_oe_n_reg));
    chk("clock mode", 9'(m), 9'(cpol_reg));
    mm.close_f();
    chk("oe released", 9'hf, 9'(lane_oe_n_reg));
    tx_en = 1'h0;
  endtask
  task automatic t_wide();
    logic [7:0] d;
    cfg(8'hc0, 1'h0);
    ext_lanes = 4'h4;
    rx_q.delete();
    mm.open_f(1'h1);
    mm.xfer(1, 1'h1, 8'h9e, d);
    exp_rx(9'h19e);
    mm.xfer(4, 1'h1, 8'h5a, d);
    exp_rx(9'h05a);
    chk("oe silent", 9'hf, 9'(lane_oe_n_reg));
    mm.close_f();
    ext_lanes = 4'h1;
  endtask
  task automatic t_fallback();
    logic [7:0] d;
    cfg(8'h40, 1'h0);
    pe_busy = 1'h1;
    vpp_hi = 1'h1;
    repeat (6) @(negedge clk);
    chk("eff fallback", 9'(MLSF_EXT), 9'(eff_proto_reg));
    chk("proto kept", 9'(MLSF_QUAD), 9'(proto_reg));
    rx_q.delete();
    mm.open_f(1'h0);
    mm.xfer(1, 1'h1, 8'h75, d);
    exp_rx(9'h175);
    mm.close_f();
    vpp_hi = 1'h0;
    repeat (6) @(negedge clk);
    chk("eff resumed", 9'(MLSF_QUAD), 9'(eff_proto_reg));
    pe_busy = 1'h0;
  endtask
  task automatic t_fifo();
    logic [7:0] d;
    cfg(8'hc0, 1'h0);
    for (int i = 0; i < 16; i++)
      push(8'(i * 17));
    @(negedge clk);
    chk("fifo full", 9'h0, 9'(tx_ready));
    tx_en = 1'h1;
    mm.open_f(1'h0);
    mm.xfer(1, 1'h1, 8'h0b, d);
    for (int i = 0; i < 17; i++)
    begin
      // serial clock stands still mid-frame while the master stalls
      if (i == 8)
        repeat (40) @(negedge clk);
      mm.xfer(1, 1'h0, 8'h00, d);
      if (i < 16)
        chk("fifo byte", 9'(i * 17), 9'(d));
      else
        chk("oe empty", 9'hf, 9'(lane_oe_n_reg));
    end
    mm.close_f();
    tx_en = 1'h0;
    chk("fifo empty", 9'h1, 9'(tx_ready));
  endtask
  initial
  begin
    boot(1'h1, 1'h1);
    t_boot();
    t_vol();
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 3; k++)
        t_frame(1'(m), 1 << k);
    t_wide();
    t_fallback();
    t_fifo();
    final_report();
  end
endmodule
`default_nettype wire
